/* File: verilog/hub_strap_config.sv */
/*
 * Strap capture and port power control of a four-port hub.
 * Assumes a 100 MHz clock; all pins are asynchronous and are synchronised here.
 */
`timescale 1ns/1ps
// Summary of operation
// RULE_01 - Low global reset puts device in reset
// RULE_02 - Board holds reset low 3 ms minimum; board_side holds it only 6 cycles past reset_request
// RULE_03 - Serial select high EEPROM, low SMBus
// RULE_04 - Data pin high disables U1/U2
// RULE_05 - Config bit overrides data pin sample
// RULE_06 - Clock pin high blocks U1/U2 initiation
// RULE_07 - Blocked initiation still accepts entry requests
// RULE_08 - Config override bit replaces clock sample
// RULE_09 - Polarity strap sets power enable level
// RULE_10 - Spread strap high disables spread spectrum
// RULE_11 - Full power strap low enables control
// RULE_12 - Ganged strap low selects per-port power
// RULE_13 - Power straps double as address bits
// RULE_14 - Power pin high enables port charging
// RULE_15 - Strap pins become power enables after
// RULE_16 - Low overcurrent input registers the event
// RULE_17 - Indicator strap doubles as address bit
// RULE_18 - Straps held until next reset
module hub_strap_config
    import strap_pkg::*;
(
    input  wire logic                      clock,
    input  wire logic                      sys_rst,
    input  wire logic                      global_reset_n,
    input  wire logic                      serial_if_select_n,
    input  wire logic                      serial_data_pin,
    input  wire logic                      serial_clock_pin,
    input  wire logic                      switch_polarity_strap,
    input  wire logic                      spread_spectrum_strap,
    input  wire logic                      full_power_mgmt_strap_n,
    input  wire logic                      ganged_power_strap,
    input  wire logic                      port_indicator_strap_n,
    input  wire logic [strap_pkg::port_count-1:0] power_en_charge_strap,
    input  wire logic [strap_pkg::port_count-1:0] overcurrent_n,
    input  wire logic                      config_present,
    input  wire logic                      lowpower_state_disable_bit,
    input  wire logic                      lowpower_initiation_override_bit,
    input  wire logic [strap_pkg::port_count-1:0] port_power_request,
    input  wire logic [strap_pkg::port_count-1:0] overcurrent_clear,
    input  wire logic                      lowpower_entry_request,
    input  wire logic                      lowpower_initiate_request,
    output logic                           device_in_reset,
    output logic                           config_valid,
    output logic                           eeprom_mode,
    output logic                           smbus_mode,
    output logic                           lowpower_states_disabled,
    output logic                           lowpower_initiation_disabled,
    output logic                           lowpower_entry_accept,
    output logic                           lowpower_initiate,
    output logic                           power_enable_active_high,
    output logic                           spread_spectrum_enable,
    output logic                           full_power_mgmt,
    output logic                           individual_power,
    output logic                           port_indicators,
    output logic [2:0]                     slave_addr_bits,
    output logic [strap_pkg::port_count-1:0] charge_enable,
    output logic [strap_pkg::port_count-1:0] overcurrent_flag,
    output logic [strap_pkg::port_count-1:0] power_en_out,
    output logic [strap_pkg::port_count-1:0] power_en_oe
);
    import strap_pkg::*;

    localparam int n = port_count;

    logic         rst_level;
    logic         sel_s;
    logic         dat_s;
    logic         clk_s;
    logic         pol_s;
    logic         ssc_s;
    logic         fpm_s;
    logic         gang_s;
    logic         ind_s;
    logic [n-1:0] chg_s;
    logic [n-1:0] oc_s;

    sync_bit #(.reset_value(1'b0)) u_rst (.clock(clock), .sys_rst(sys_rst), .pin(global_reset_n), .level(rst_level));
    sync_bit #(.reset_value(serial_if_reset)) u_sel (.clock(clock), .sys_rst(sys_rst), .pin(serial_if_select_n),
        .level(sel_s));
    sync_bit #(.reset_value(1'b0)) u_dat (.clock(clock), .sys_rst(sys_rst), .pin(serial_data_pin), .level(dat_s));
    sync_bit #(.reset_value(1'b0)) u_clk (.clock(clock), .sys_rst(sys_rst), .pin(serial_clock_pin), .level(clk_s));
    sync_bit #(.reset_value(polarity_reset)) u_pol (.clock(clock), .sys_rst(sys_rst), .pin(switch_polarity_strap),
        .level(pol_s));
    sync_bit #(.reset_value(spread_reset)) u_ssc (.clock(clock), .sys_rst(sys_rst), .pin(spread_spectrum_strap),
        .level(ssc_s));
    sync_bit #(.reset_value(full_pwr_n_reset)) u_fpm (.clock(clock), .sys_rst(sys_rst),
        .pin(full_power_mgmt_strap_n), .level(fpm_s));
    sync_bit #(.reset_value(ganged_reset)) u_gang (.clock(clock), .sys_rst(sys_rst), .pin(ganged_power_strap),
        .level(gang_s));
    sync_bit #(.reset_value(indicator_n_reset)) u_ind (.clock(clock), .sys_rst(sys_rst),
        .pin(port_indicator_strap_n), .level(ind_s));

    genvar g;
    generate
        for (g = 0; g < n; g++) begin : g_port
            sync_bit #(.reset_value(1'b0)) u_chg (.clock(clock), .sys_rst(sys_rst),
                .pin(power_en_charge_strap[g]), .level(chg_s[g]));
            sync_bit #(.reset_value(1'b1)) u_oc (.clock(clock), .sys_rst(sys_rst),
                .pin(overcurrent_n[g]), .level(oc_s[g]));
        end
    endgenerate

    phase_type    phase;
    phase_type    next_phase;
    logic         sel_q;
    logic         dat_q;
    logic         clk_q;
    logic         pol_q;
    logic         ssc_q;
    logic         fpm_q;
    logic         gang_q;
    logic         ind_q;
    logic [n-1:0] chg_q;
    logic [n-1:0] oc_flag;
    logic         next_sel;
    logic         next_dat;
    logic         next_clk;
    logic         next_pol;
    logic         next_ssc;
    logic         next_fpm;
    logic         next_gang;
    logic         next_ind;
    logic [n-1:0] next_chg;
    logic [n-1:0] next_oc_flag;
    logic         running;

    always_comb begin
        next_phase   = phase;
        next_sel     = sel_q;
        next_dat     = dat_q;
        next_clk     = clk_q;
        next_pol     = pol_q;
        next_ssc     = ssc_q;
        next_fpm     = fpm_q;
        next_gang    = gang_q;
        next_ind     = ind_q;
        next_chg     = chg_q;
        next_oc_flag = oc_flag;
        if (!rst_level) begin
            next_phase   = phase_reset;                     // [RULE_01]
            next_oc_flag = '0;
        end else begin
            unique case (phase)
                phase_reset: begin
                    next_phase = phase_sample;
                end
                phase_sample: begin
                    // Straps captured on the first cycle after release
                    next_sel   = sel_s;                         // [RULE_03]
                    next_dat   = dat_s;                         // [RULE_04]
                    next_clk   = clk_s;                         // [RULE_06]
                    next_pol   = pol_s;                         // [RULE_09]
                    next_ssc   = ssc_s;                         // [RULE_10]
                    next_fpm   = fpm_s;                         // [RULE_11]
                    next_gang  = gang_s;                        // [RULE_12]
                    next_ind   = ind_s;                         // [RULE_17]
                    next_chg   = chg_s;                         // [RULE_14]
                    next_phase = phase_run;
                end
                phase_run: begin
                    // Straps hold here until reset returns
                    next_phase   = phase_run;                   // [RULE_18]
                    next_oc_flag = (oc_flag & ~overcurrent_clear) | ~oc_s;  // [RULE_16]
                end
                default: begin
                    next_phase = phase_reset;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            phase   <= phase_reset;
            sel_q   <= serial_if_reset;
            dat_q   <= 1'b0;
            clk_q   <= 1'b0;
            pol_q   <= polarity_reset;
            ssc_q   <= spread_reset;
            fpm_q   <= full_pwr_n_reset;
            gang_q  <= ganged_reset;
            ind_q   <= indicator_n_reset;
            chg_q   <= charge_reset;
            oc_flag <= '0;
        end else begin
            phase   <= next_phase;
            sel_q   <= next_sel;
            dat_q   <= next_dat;
            clk_q   <= next_clk;
            pol_q   <= next_pol;
            ssc_q   <= next_ssc;
            fpm_q   <= next_fpm;
            gang_q  <= next_gang;
            ind_q   <= next_ind;
            chg_q   <= next_chg;
            oc_flag <= next_oc_flag;
        end
    end

    assign running                      = (phase == phase_run);
    assign device_in_reset              = !running;
    assign config_valid                 = running;
    assign eeprom_mode                  = sel_q;
    assign smbus_mode                   = !sel_q;
    // Configuration source wins over the pin samples
    assign lowpower_states_disabled     = config_present ? lowpower_state_disable_bit : dat_q;         // [RULE_05]
    assign lowpower_initiation_disabled = config_present ? lowpower_initiation_override_bit : clk_q;   // [RULE_08]
    assign lowpower_entry_accept        = running && lowpower_entry_request && !lowpower_states_disabled; // [RULE_07]
    assign lowpower_initiate            = running && lowpower_initiate_request && !lowpower_states_disabled
                                          && !lowpower_initiation_disabled;                           // [RULE_07]
    assign power_enable_active_high     = pol_q;
    assign spread_spectrum_enable       = !ssc_q;
    assign full_power_mgmt              = !fpm_q;
    assign individual_power             = !gang_q;
    assign port_indicators              = !ind_q;
    assign slave_addr_bits              = smbus_mode ? {ind_q, gang_q, fpm_q} : 3'h0;   // [RULE_13] [RULE_17]
    assign charge_enable                = chg_q;
    assign overcurrent_flag             = oc_flag;
    // Pins stay released during reset so pulls set the strap level
    assign power_en_oe                  = {n{running}};                                  // [RULE_15]
    assign power_en_out                 = pol_q ? port_power_request : ~port_power_request; // [RULE_15]

    chk_reset_drops_config: assert property (@(posedge clock) disable iff (sys_rst)
        !rst_level |=> !config_valid) else $error("config stayed valid under reset"); // [RULE_01]
    chk_straps_hold: assert property (@(posedge clock) disable iff (sys_rst)
        running && $past(running) |-> $stable(chg_q) && $stable(pol_q) && $stable(sel_q))
        else $error("strap changed while running"); // [RULE_18]
    chk_release_to_run: assert property (@(posedge clock) disable iff (sys_rst)
        $rose(rst_level) && phase == phase_reset |=> ##1 config_valid [*2])
        else $error("run not reached two cycles after release"); // [RULE_01]
    chk_u1u2_pin: assert property (@(posedge clock) disable iff (sys_rst)
        running && !config_present |-> lowpower_states_disabled == dat_q)
        else $error("lowpower disable not from pin"); // [RULE_04]
    chk_no_initiation: assert property (@(posedge clock) disable iff (sys_rst)
        lowpower_initiation_disabled |-> !lowpower_initiate) else $error("initiated while blocked"); // [RULE_06]
    chk_accept_kept: assert property (@(posedge clock) disable iff (sys_rst)
        running && lowpower_entry_request && !lowpower_states_disabled |-> lowpower_entry_accept)
        else $error("entry request refused"); // [RULE_07]
    chk_oc_sticky: assert property (@(posedge clock) disable iff (sys_rst)
        running && rst_level && !oc_s[0] |=> overcurrent_flag[0]) else $error("overcurrent lost"); // [RULE_16]
    chk_power_level: assert property (@(posedge clock) disable iff (sys_rst)
        running && !pol_q |-> power_en_out == ~port_power_request) else $error("power enable level wrong"); // [RULE_15]
endmodule // hub_strap_config

/* File: inc/strap_pkg.sv */
/*
 * Constants and types for the reset and strap configuration block of a
 * four-port hub. Assumes a 100 MHz system clock.
 */
package strap_pkg;
    localparam int          port_count       = 4;
    localparam int          clock_period_ns  = 10;
    localparam int          reset_hold_ms    = 3;
    localparam int          reset_hold_cycles = (reset_hold_ms * 1000000) / clock_period_ns;
    localparam int          sync_stages      = 2;
    // Strap defaults loaded by sys_rst, shown until the first strap capture
    localparam logic        serial_if_reset   = 1'b1;
    localparam logic        polarity_reset    = 1'b0;
    localparam logic        spread_reset      = 1'b0;
    localparam logic        full_pwr_n_reset  = 1'b1;
    localparam logic        ganged_reset      = 1'b1;
    localparam logic        indicator_n_reset = 1'b1;
    localparam logic [3:0]  charge_reset      = 4'h0;

    typedef enum logic [1:0] {
        phase_reset,
        phase_sample,
        phase_run
    } phase_type;
endpackage

/* File: verilog/sync_bit.sv */
/*
 * Two flip-flop synchroniser for one pin level.
 * Assumes the input is asynchronous to clock.
 */
`timescale 1ns/1ps
module sync_bit #(
    parameter logic reset_value = 1'b0
) (
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level
);
    logic first;
    logic next_first;
    logic next_level;

    always_comb begin
        next_first = pin;
        next_level = first;
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            first <= reset_value;
            level <= reset_value;
        end else begin
            first <= next_first;
            level <= next_level;
        end
    end
endmodule // sync_bit

/* File: bench/board_side.sv */
/*
 * Board side model: reset circuit, strap resistors and port power controllers.
 * Assumes the bench asks for reset and sets strap levels, already in the clock domain.
 */
`timescale 1ns/1ps
module board_side #(
    parameter int hold_cycles = 6
) (
    input  wire logic        clock,
    input  wire logic        reset_request,
    input  wire logic [11:0] strap_value,
    input  wire logic [3:0]  overcurrent_request,
    input  wire logic [3:0]  power_en_out,
    input  wire logic [3:0]  power_en_oe,
    output logic             global_reset_n,
    output logic [7:0]       strap_pins,
    output logic [3:0]       power_en_charge_strap,
    output logic [3:0]       overcurrent_n
);
    logic [15:0] hold_count = 16'h0000;

    // Scaled stand-in for the long board reset hold
    always_ff @(posedge clock) begin
        if (reset_request) begin
            hold_count <= 16'(hold_cycles);
        end else if (hold_count != 16'h0000) begin
            hold_count <= hold_count - 16'h0001;
        end
    end
    assign global_reset_n = !reset_request && (hold_count == 16'h0000);
    assign strap_pins = strap_value[7:0];
    // Resistor level shows only while the device leaves the pin undriven
    assign power_en_charge_strap = (power_en_oe & power_en_out) | (~power_en_oe & strap_value[11:8]);
    assign overcurrent_n = ~overcurrent_request;
endmodule // board_side

/* File: bench/test_hub_strap_config.sv */
/*
 * Self-checking bench for the strap capture block.
 * Assumes board_side for pins; strap bits: 0 select_n, 1 data, 2 clk, 3 polarity, 4 spread,
 * 5 full_n, 6 ganged, 7 indicator_n, 11:8 charge.
 */
`timescale 1ns/1ps
module test_hub_strap_config;
    import strap_pkg::*;
    logic clock = 1'b0, sys_rst = 1'b1, reset_request = 1'b1, cfg = 1'b0, dis_bit = 1'b0, ovr_bit = 1'b0;
    logic entry_req = 1'b0, init_req = 1'b0;
    logic [11:0] strap = 12'h0E1;
    logic [3:0] oc_req = 4'h0, request = 4'h0, oc_clear = 4'h0;
    logic global_reset_n, device_in_reset, config_valid, eeprom_mode, smbus_mode, lp_dis, lp_init_dis;
    logic entry_accept, initiate, active_high, spread_en, full_pm, indiv, indicators;
    logic [2:0] addr;
    logic [7:0] pins;
    logic [3:0] pin_in, oc_n, charge, oc_flag, pen_out, pen_oe;
    int failures = 0, checked = 0;
    always #5 clock = ~clock;
    board_side u_board_side (.clock(clock), .reset_request(reset_request), .strap_value(strap),
        .overcurrent_request(oc_req), .power_en_out(pen_out), .power_en_oe(pen_oe),
        .global_reset_n(global_reset_n), .strap_pins(pins), .power_en_charge_strap(pin_in),
        .overcurrent_n(oc_n));
    hub_strap_config u_hub_strap_config (.clock(clock), .sys_rst(sys_rst), .global_reset_n(global_reset_n),
        .serial_if_select_n(pins[0]), .serial_data_pin(pins[1]), .serial_clock_pin(pins[2]),
        .switch_polarity_strap(pins[3]), .spread_spectrum_strap(pins[4]), .full_power_mgmt_strap_n(pins[5]),
        .ganged_power_strap(pins[6]), .port_indicator_strap_n(pins[7]), .power_en_charge_strap(pin_in),
        .overcurrent_n(oc_n), .config_present(cfg), .lowpower_state_disable_bit(dis_bit),
        .lowpower_initiation_override_bit(ovr_bit), .port_power_request(request), .overcurrent_clear(oc_clear),
        .lowpower_entry_request(entry_req), .lowpower_initiate_request(init_req),
        .device_in_reset(device_in_reset), .config_valid(config_valid), .eeprom_mode(eeprom_mode),
        .smbus_mode(smbus_mode), .lowpower_states_disabled(lp_dis), .lowpower_initiation_disabled(lp_init_dis),
        .lowpower_entry_accept(entry_accept), .lowpower_initiate(initiate),
        .power_enable_active_high(active_high), .spread_spectrum_enable(spread_en), .full_power_mgmt(full_pm),
        .individual_power(indiv), .port_indicators(indicators), .slave_addr_bits(addr), .charge_enable(charge),
        .overcurrent_flag(oc_flag), .power_en_out(pen_out), .power_en_oe(pen_oe));

    task automatic close_out();
        if (failures == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input logic [3:0] got, input logic [3:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic step(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic boot();
        int i;
        reset_request = 1'b1;
        step(1);
        for (i = 0; i < 20 && device_in_reset !== 1'b1; i++) step(1);
        chk(device_in_reset, 1'b1, "in reset");
        chk(pen_oe, 4'h0, "oe in reset");
        chk(oc_flag, 4'h0, "flags cleared");
        reset_request = 1'b0;
        for (i = 0; i < 60 && config_valid !== 1'b1; i++) step(1);
        if (config_valid !== 1'b1) begin
            failures++;
            $display("MISMATCH %0t config never valid", $time);
            close_out();
        end
    endtask

    task automatic verify(input logic [11:0] s);
        chk(eeprom_mode, s[0], "eeprom");
        chk(smbus_mode, !s[0], "smbus");
        chk(config_valid, 1'b1, "valid");
        chk(device_in_reset, 1'b0, "running");
        chk(lp_dis, cfg ? dis_bit : s[1], "u1u2 off");
        chk(lp_init_dis, cfg ? ovr_bit : s[2], "init off");
        chk(active_high, s[3], "polarity");
        chk(spread_en, !s[4], "spread");
        chk(full_pm, !s[5], "full pm");
        chk(indiv, !s[6], "individual");
        chk(indicators, !s[7], "indicators");
        chk(addr, s[0] ? 3'h0 : s[7:5], "address");
        chk(charge, s[11:8], "charge");
        chk(pen_oe, 4'hF, "oe run");
        chk(pen_out, s[3] ? request : ~request, "power out");
        entry_req = 1'b1;
        init_req = 1'b1;
        step(1);
        chk(entry_accept, !(cfg ? dis_bit : s[1]), "entry accepted");
        chk(initiate, !(cfg ? (dis_bit | ovr_bit) : (s[1] | s[2])), "initiate");
        entry_req = 1'b0;
        init_req = 1'b0;
    endtask

    initial begin
        logic [11:0] table_s [4] = '{12'h0E1, 12'hF1E, 12'h5A6, 12'hA5B};
        step(3);
        sys_rst = 1'b0;
        for (int k = 0; k < 4; k++) begin
            strap = table_s[k];
            cfg = k[1];
            dis_bit = k[0];
            ovr_bit = ~k[0];
            request = 4'(k * 5 + 3);
            boot();
            verify(table_s[k]);
            strap = ~table_s[k];
            step(8);
            verify(table_s[k]);
        end
        oc_req = 4'h6;
        step(5);
        chk(oc_flag, 4'h6, "oc set");
        oc_req = 4'h0;
        step(3);
        oc_clear = 4'h2;
        step(1);
        oc_clear = 4'h0;
        step(1);
        chk(oc_flag, 4'h4, "oc clear");
        boot();
        verify(~table_s[3]);
        close_out();
    end
endmodule // test_hub_strap_config
